// ==== shared/fpc_pkg.sv ====
// package with register map, field layout, codes and carrier types of the flash control block
package fpc_pkg;
   // register byte offsets
   localparam logic [8:0] OFS_CTRL = 9'h000;
   localparam logic [8:0] OFS_KEY = 9'h020;
   localparam logic [8:0] OFS_TADDR = 9'h030;
   localparam logic [8:0] OFS_DATA0 = 9'h040;
   localparam logic [8:0] OFS_DATA1 = 9'h050;
   localparam logic [8:0] OFS_DATA2 = 9'h060;
   localparam logic [8:0] OFS_DATA3 = 9'h070;
   localparam logic [8:0] OFS_SRC = 9'h0C0;
   localparam logic [8:0] OFS_LOWLIM = 9'h0D0;
   localparam logic [8:0] OFS_HIGHLIM = 9'h0E0;
   localparam logic [8:0] OFS_BOOT = 9'h0F0;
   localparam logic [8:0] OFS_IRQ_STAT = 9'h100;
   localparam logic [8:0] OFS_IRQ_MASK = 9'h104;
   localparam logic [8:0] OFS_LINE_STAT = 9'h108;
   // control register fields
   localparam int BIT_TRIGGER = 15;
   localparam int BIT_ARM = 14;
   localparam int BIT_FAIL = 13;
   localparam int BIT_LOWSUP = 12;
   localparam int BIT_HOT = 8;
   localparam int OPSEL_MSB = 3;
   // protection register fields
   localparam int LIMIT_MSB = 23;
   localparam int BIT_FREEZE = 31;
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   localparam logic [23:0] LIMIT_NONE = 24'h00_0000;
   // interrupt status bits
   localparam int IRQ_DONE = 0;
   localparam int IRQ_FAIL = 1;
   localparam int IRQ_LOWSUP = 2;
   localparam int IRQ_HOT = 3;
   localparam int IRQ_W = 4;
   // operation codes
   localparam logic [3:0] OP_NOP = 4'h0;
   localparam logic [3:0] OP_WORD = 4'h1;
   localparam logic [3:0] OP_QUAD = 4'h2;
   localparam logic [3:0] OP_ROW = 4'h3;
   localparam logic [3:0] OP_PAGE_ERASE = 4'h4;
   localparam logic [3:0] OP_ERASE_LOW = 4'h5;
   localparam logic [3:0] OP_ERASE_UP = 4'h6;
   localparam logic [3:0] OP_ERASE_ALL = 4'h7;
   localparam logic [3:0] OP_CHIP_ERASE = 4'hE;
   // unlock key words, values arbitrary
   localparam logic [31:0] KEY_FIRST = 32'h5A5A_0F0F;
   localparam logic [31:0] KEY_SECOND = 32'hA5A5_F0F0;
   // top byte of an address that falls in the boot partition, value arbitrary
   localparam logic [7:0] BOOT_REGION_TAG = 8'h1F;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_CHECK = 4'b0010,
      ST_BUSY = 4'b0100,
      ST_FINISH = 4'b1000
   } fpc_state_t;

   typedef enum logic [2:0] {
      KEY_NONE = 3'b001,
      KEY_HALF = 3'b010,
      KEY_OPEN = 3'b100
   } fpc_key_t;

   // command carried to the flash array
   typedef struct packed {
      logic [3:0] op;
      logic [31:0] addr;
      logic [31:0] src;
      logic [127:0] data;
   } fpc_flash_cmd_t;
endpackage

// ==== verilog/fpc_flash_ctrl.sv ====
// flash program and erase sequencer with write protection and register slave
`timescale 1ns/1ps

module fpc_flash_ctrl
   import fpc_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [8:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic thermal_ok,
   input wire logic low_supply_detect,
   input wire logic high_temp_detect,
   output logic flash_start,
   output fpc_flash_cmd_t flash_cmd,
   input wire logic flash_done,
   input wire logic flash_fail,
   output logic irq
);
   // pin synchronisers: bit 0 thermal ok, bit 1 low supply, bit 2 high temperature
   logic [2:0] sync1_q;
   logic [2:0] sync2_q;
   logic temp_ok_s;
   logic lowsup_s;
   logic hot_s;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sync1_q <= 3'h0;
         sync2_q <= 3'h0;
      end else begin
         sync1_q <= {high_temp_detect, low_supply_detect, thermal_ok};
         sync2_q <= sync1_q;
      end
   end

   assign temp_ok_s = sync2_q[0];
   assign lowsup_s = sync2_q[1];
   assign hot_s = sync2_q[2];

   // bus slave: one wait cycle, then the answer
   logic ack_q;
   logic ack_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic wr_take;

   // register state
   logic trigger_q, trigger_d;
   logic arm_q, arm_d;
   logic fail_q, fail_d;
   logic lowsup_q, lowsup_d;
   logic hot_q, hot_d;
   logic [3:0] opsel_q, opsel_d;
   fpc_key_t key_q, key_d;
   logic [31:0] taddr_q, taddr_d;
   logic [31:0] data_q [4];
   logic [31:0] data_d [4];
   logic [31:0] src_q, src_d;
   logic [31:0] lowlim_q, lowlim_d;
   logic [31:0] highlim_q, highlim_d;
   logic [31:0] boot_q, boot_d;
   logic [IRQ_W-1:0] istat_q, istat_d;
   logic [IRQ_W-1:0] imask_q, imask_d;
   fpc_state_t state_q, state_d;
   logic start_q, start_d;
   logic op_ok_q, op_ok_d;
   logic [IRQ_W-1:0] ev;

   // byte-lane merge of a write into a stored word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // true when the target lies in a protected page
   function automatic logic target_protected(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi,
                                             input logic [31:0] bt);
      logic p;
      p = 1'b0;
      if (a[31:24] == BOOT_REGION_TAG) begin
         p = (a[LIMIT_MSB:0] < bt[LIMIT_MSB:0]);
      end else begin
         if (a[LIMIT_MSB:0] < lo[LIMIT_MSB:0]) begin
            p = 1'b1;
         end
         if ((hi[LIMIT_MSB:0] != LIMIT_NONE) && (a[LIMIT_MSB:0] >= hi[LIMIT_MSB:0])) begin
            p = 1'b1;
         end
      end
      return p;
   endfunction

   assign wr_take = avs_write & ack_q;

   always_comb begin
      ack_d = (avs_read | avs_write) & ~ack_q;
      rdata_d = rdata_q;
      if (avs_read && !ack_q) begin
         rdata_d = RESET_WORD;
         if (avs_address == OFS_CTRL) begin
            rdata_d[BIT_TRIGGER] = trigger_q;
            rdata_d[BIT_ARM] = arm_q;
            rdata_d[BIT_FAIL] = fail_q;
            rdata_d[BIT_LOWSUP] = lowsup_q;
            rdata_d[BIT_HOT] = hot_q;
            rdata_d[OPSEL_MSB:0] = opsel_q;
         end else if (avs_address == OFS_TADDR) begin
            rdata_d = taddr_q;
         end else if (avs_address == OFS_DATA0) begin
            rdata_d = data_q[0];
         end else if (avs_address == OFS_DATA1) begin
            rdata_d = data_q[1];
         end else if (avs_address == OFS_DATA2) begin
            rdata_d = data_q[2];
         end else if (avs_address == OFS_DATA3) begin
            rdata_d = data_q[3];
         end else if (avs_address == OFS_SRC) begin
            rdata_d = src_q;
         end else if (avs_address == OFS_LOWLIM) begin
            rdata_d = lowlim_q;
         end else if (avs_address == OFS_HIGHLIM) begin
            rdata_d = highlim_q;
         end else if (avs_address == OFS_BOOT) begin
            rdata_d = boot_q;
         end else if (avs_address == OFS_IRQ_STAT) begin
            rdata_d[IRQ_W-1:0] = istat_q;
         end else if (avs_address == OFS_IRQ_MASK) begin
            rdata_d[IRQ_W-1:0] = imask_q;
         end else if (avs_address == OFS_LINE_STAT) begin
            rdata_d[2:0] = {hot_s, lowsup_s, temp_ok_s};
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ack_q <= 1'b0;
         rdata_q <= RESET_WORD;
      end else begin
         ack_q <= ack_d;
         rdata_q <= rdata_d;
      end
   end

   assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
   assign avs_readdata = rdata_q;

   // registers and sequencer
   always_comb begin
      trigger_d = trigger_q;
      arm_d = arm_q;
      fail_d = fail_q;
      lowsup_d = lowsup_q;
      hot_d = hot_q;
      opsel_d = opsel_q;
      key_d = key_q;
      taddr_d = taddr_q;
      data_d = data_q;
      src_d = src_q;
      lowlim_d = lowlim_q;
      highlim_d = highlim_q;
      boot_d = boot_q;
      imask_d = imask_q;
      state_d = state_q;
      start_d = 1'b0;
      op_ok_d = op_ok_q;
      ev = '0;

      if (wr_take) begin
         // any write other than a key word ends the unlock window
         if (avs_address != OFS_KEY) begin
            key_d = KEY_NONE;
         end
         if (avs_address == OFS_CTRL) begin
            if (avs_byteenable[1]) begin
               arm_d = avs_writedata[BIT_ARM];
               // trigger gated by arm, thermal ok and unlock
               if (avs_writedata[BIT_TRIGGER] && arm_q && temp_ok_s && (key_q == KEY_OPEN) && !trigger_q) begin
                  trigger_d = 1'b1;
                  state_d = ST_CHECK;
               end
            end
            if (avs_byteenable[0] && !arm_q) begin
               opsel_d = avs_writedata[OPSEL_MSB:0];
            end
         end else if (avs_address == OFS_KEY) begin
            if (&avs_byteenable && (avs_writedata == KEY_FIRST)) begin
               key_d = KEY_HALF;
            end else if (&avs_byteenable && (avs_writedata == KEY_SECOND) && (key_q == KEY_HALF)) begin
               key_d = KEY_OPEN;
            end else begin
               key_d = KEY_NONE;
            end
         end else if (avs_address == OFS_TADDR) begin
            taddr_d = merge(taddr_q, avs_writedata, avs_byteenable);
         end else if (avs_address == OFS_DATA0) begin
            data_d[0] = merge(data_q[0], avs_writedata, avs_byteenable);
         end else if (avs_address == OFS_DATA1) begin
            data_d[1] = merge(data_q[1], avs_writedata, avs_byteenable);
         end else if (avs_address == OFS_DATA2) begin
            data_d[2] = merge(data_q[2], avs_writedata, avs_byteenable);
         end else if (avs_address == OFS_DATA3) begin
            data_d[3] = merge(data_q[3], avs_writedata, avs_byteenable);
         end else if (avs_address == OFS_SRC) begin
            src_d = merge(src_q, avs_writedata, avs_byteenable);
         end else if (avs_address == OFS_LOWLIM) begin
            // change needs unlock and no freeze
            if ((key_q == KEY_OPEN) && !lowlim_q[BIT_FREEZE]) begin
               lowlim_d = merge(lowlim_q, avs_writedata, avs_byteenable);
            end
         end else if (avs_address == OFS_HIGHLIM) begin
            // change needs unlock and no freeze
            if ((key_q == KEY_OPEN) && !highlim_q[BIT_FREEZE]) begin
               highlim_d = merge(highlim_q, avs_writedata, avs_byteenable);
            end
         end else if (avs_address == OFS_BOOT) begin
            // change needs unlock and no freeze
            if ((key_q == KEY_OPEN) && !boot_q[BIT_FREEZE]) begin
               boot_d = merge(boot_q, avs_writedata, avs_byteenable);
            end
         end else if (avs_address == OFS_IRQ_MASK) begin
            imask_d = avs_writedata[IRQ_W-1:0];
         end
      end

      case (state_q)
         ST_IDLE: begin
         end
         ST_CHECK: begin
            case (opsel_q)
               OP_NOP: begin
                  fail_d = 1'b0;
                  lowsup_d = 1'b0;
                  hot_d = 1'b0;
                  op_ok_d = 1'b1;
                  state_d = ST_FINISH;
               end
               OP_WORD, OP_QUAD, OP_ROW, OP_PAGE_ERASE: begin
                  if (target_protected(taddr_q, lowlim_q, highlim_q, boot_q)) begin
                     op_ok_d = 1'b0;
                     state_d = ST_FINISH;
                  end else begin
                     start_d = 1'b1;
                     state_d = ST_BUSY;
                  end
               end
               OP_ERASE_LOW, OP_ERASE_UP, OP_ERASE_ALL: begin
                  // array erases need both low and high limits at none; the boot limit is not checked
                  if ((lowlim_q[LIMIT_MSB:0] != LIMIT_NONE) || (highlim_q[LIMIT_MSB:0] != LIMIT_NONE)) begin
                     op_ok_d = 1'b0;
                     state_d = ST_FINISH;
                  end else begin
                     start_d = 1'b1;
                     state_d = ST_BUSY;
                  end
               end
               default: begin
                  // chip erase is debug-port only; reserved codes fail
                  op_ok_d = 1'b0;
                  state_d = ST_FINISH;
               end
            endcase
         end
         ST_BUSY: begin
            // low supply captured while operation runs
            if (lowsup_s) begin
               lowsup_d = 1'b1;
            end
            // high temperature captured while operation runs
            if (hot_s) begin
               hot_d = 1'b1;
            end
            if (flash_done) begin
               op_ok_d = ~flash_fail;
               state_d = ST_FINISH;
            end
         end
         ST_FINISH: begin
            if (opsel_q != OP_NOP) begin
               fail_d = ~op_ok_q;
            end
            trigger_d = 1'b0;
            state_d = ST_IDLE;
            ev[IRQ_DONE] = 1'b1;
            ev[IRQ_FAIL] = ~op_ok_q;
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase

      ev[IRQ_LOWSUP] = lowsup_d & ~lowsup_q;
      ev[IRQ_HOT] = hot_d & ~hot_q;
      // sticky status: write one to clear, a new event wins
      istat_d = istat_q;
      if (wr_take && (avs_address == OFS_IRQ_STAT)) begin
         istat_d = istat_q & ~avs_writedata[IRQ_W-1:0];
      end
      istat_d = istat_d | ev;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         trigger_q <= 1'b0;
         arm_q <= 1'b0;
         fail_q <= 1'b0;
         lowsup_q <= 1'b0;
         hot_q <= 1'b0;
         opsel_q <= OP_NOP;
         key_q <= KEY_NONE;
         taddr_q <= RESET_WORD;
         for (int i = 0; i < 4; i++) begin
            data_q[i] <= RESET_WORD;
         end
         src_q <= RESET_WORD;
         lowlim_q <= RESET_WORD;
         highlim_q <= RESET_WORD;
         boot_q <= RESET_WORD;
         istat_q <= '0;
         imask_q <= '0;
         state_q <= ST_IDLE;
         start_q <= 1'b0;
         op_ok_q <= 1'b0;
      end else begin
         trigger_q <= trigger_d;
         arm_q <= arm_d;
         fail_q <= fail_d;
         lowsup_q <= lowsup_d;
         hot_q <= hot_d;
         opsel_q <= opsel_d;
         key_q <= key_d;
         taddr_q <= taddr_d;
         data_q <= data_d;
         src_q <= src_d;
         lowlim_q <= lowlim_d;
         highlim_q <= highlim_d;
         boot_q <= boot_d;
         istat_q <= istat_d;
         imask_q <= imask_d;
         state_q <= state_d;
         start_q <= start_d;
         op_ok_q <= op_ok_d;
      end
   end

   assign flash_start = start_q;
   assign flash_cmd.addr = taddr_q;
   assign flash_cmd.op = opsel_q;
   assign flash_cmd.src = src_q;
   // four data words, word 0 lowest
   assign flash_cmd.data = {data_q[3], data_q[2], data_q[1], data_q[0]};
   assign irq = |(istat_q & imask_q);
endmodule

// ==== bench/fpc_flash_ctrl_chk.sv ====
// port assertions for the flash control block
`timescale 1ns/1ps
module fpc_flash_ctrl_chk
   import fpc_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [8:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic flash_start,
   input wire fpc_flash_cmd_t flash_cmd
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   a_read_wait: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("read not answered after one wait cycle");
   a_write_wait: assert property ($rose(avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("write not answered after one wait cycle");
   a_idle_no_wait: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
      else $error("waitrequest high without a request");
   a_rdata_hold: assert property (!avs_read |=> $stable(avs_readdata))
      else $error("read data changed without a read");
   a_start_pulse: assert property (flash_start |=> !flash_start)
      else $error("start longer than one cycle");
   a_start_gap: assert property (flash_start |=> (!flash_start) [*3])
      else $error("second start too soon");
   a_start_cause: assert property (flash_start |-> $past(avs_write && !avs_waitrequest
      && avs_address == OFS_CTRL && avs_writedata[BIT_TRIGGER], 2))
      else $error("start without accepted trigger write");
   a_start_code: assert property (flash_start |-> flash_cmd.op >= OP_WORD && flash_cmd.op <= OP_ERASE_ALL)
      else $error("start with a code that is not an array operation");
endmodule
bind fpc_flash_ctrl fpc_flash_ctrl_chk fpc_flash_ctrl_chk_inst (.clk, .reset_n, .avs_address, .avs_read,
   .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .flash_start, .flash_cmd);

// ==== bench/fpc_flash_model.sv ====
// behavioural flash array answering start commands
`timescale 1ns/1ps
module fpc_flash_model
   import fpc_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic flash_start,
   input wire fpc_flash_cmd_t flash_cmd,
   input wire logic [7:0] delay,
   input wire logic fail_next,
   output logic flash_done,
   output logic flash_fail,
   output fpc_flash_cmd_t last_cmd,
   output logic [7:0] starts
);
   logic [7:0] cnt_q;
   logic busy_q;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q <= 8'h00;
         busy_q <= 1'b0;
         flash_done <= 1'b0;
         flash_fail <= 1'b0;
         last_cmd <= '0;
         starts <= 8'h00;
      end else begin
         flash_done <= 1'b0;
         // fail is only meaningful with done, so it keeps changing otherwise
         flash_fail <= ~flash_fail;
         if (flash_start) begin
            busy_q <= 1'b1;
            cnt_q <= delay;
            last_cmd <= flash_cmd;
            starts <= starts + 8'h01;
         end else if (busy_q) begin
            if (cnt_q == 8'h00) begin
               busy_q <= 1'b0;
               flash_done <= 1'b1;
               flash_fail <= fail_next;
            end else begin
               cnt_q <= cnt_q - 8'h01;
            end
         end
      end
   end
endmodule

// ==== bench/test_flash_program_erase_control.sv ====
// self-checking bench for the flash control block
`timescale 1ns/1ps
module test_flash_program_erase_control;
   import fpc_pkg::*;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [8:0] avs_address = 9'h000;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hF;
   logic [31:0] avs_readdata, rd;
   logic avs_waitrequest, flash_start, flash_done, flash_fail, irq;
   logic thermal_ok = 1'b0, low_supply_detect = 1'b0, high_temp_detect = 1'b0, fail_next = 1'b0;
   logic [7:0] delay = 8'h04, starts, s0;
   fpc_flash_cmd_t flash_cmd, last_cmd;
   int n_mismatch = 0, checks_done = 0;
   logic [8:0] pr [3] = '{OFS_LOWLIM, OFS_HIGHLIM, OFS_BOOT};
   logic [31:0] lim [3] = '{32'h200, 32'h800, 32'h1000};
   logic [31:0] ta [3] = '{32'h100, 32'h900, 32'h1F00_0100};
   always #10 clk = ~clk;
   fpc_flash_ctrl fpc_flash_ctrl_inst (.clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .thermal_ok, .low_supply_detect, .high_temp_detect,
      .flash_start, .flash_cmd, .flash_done, .flash_fail, .irq);
   fpc_flash_model fpc_flash_model_inst (.clk, .reset_n, .flash_start, .flash_cmd, .delay, .fail_next,
      .flash_done, .flash_fail, .last_cmd, .starts);
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // holds the request until waitrequest is seen low, then takes the answer edge
   task automatic wait_ack();
      @(negedge clk);
      while (avs_waitrequest !== 1'b0) begin
         @(negedge clk);
      end
      @(posedge clk);
   endtask
   task automatic bus_wr(input logic [8:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= 1'b1;
      wait_ack();
      avs_write <= 1'b0;
      @(posedge clk);
   endtask
   task automatic bus_rd(input logic [8:0] a, output logic [31:0] d);
      avs_address <= a;
      avs_read <= 1'b1;
      wait_ack();
      d = avs_readdata;
      avs_read <= 1'b0;
      @(posedge clk);
   endtask
   task automatic unlock();
      bus_wr(OFS_KEY, KEY_FIRST);
      bus_wr(OFS_KEY, KEY_SECOND);
   endtask
   // disarm, select, arm, unlock, trigger, then poll until idle
   task automatic run_op(input logic [3:0] op, input logic ok, output logic [31:0] c);
      int i;
      s0 = starts;
      bus_wr(OFS_CTRL, {28'h0, op});
      bus_wr(OFS_CTRL, {28'h0400, op});
      unlock();
      bus_wr(OFS_CTRL, {28'h0C00, op});
      i = 0;
      c = 32'h8000;
      while (c[BIT_TRIGGER] !== 1'b0 && i < 100) begin
         bus_rd(OFS_CTRL, c);
         i++;
      end
      check("trigger cleared", c[BIT_TRIGGER], 1'b0);
      check("start count", 8'(starts - s0), {7'h0, ok});
   endtask
   initial begin
      #1_000_000;
      n_mismatch++;
      final_report();
   end
   initial begin
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      bus_rd(OFS_CTRL, rd);
      check("ctrl reset", rd, RESET_WORD);
      bus_wr(OFS_KEY, 32'hFFFF_FFFF);
      bus_rd(OFS_KEY, rd);
      check("key write only", rd, 32'h0);
      bus_rd(9'h1FC, rd);
      check("unmapped", rd, 32'h0);
      run_op(OP_WORD, 1'b0, rd);
      thermal_ok <= 1'b1;
      bus_wr(OFS_IRQ_MASK, 32'hF);
      bus_wr(OFS_CTRL, 32'h1);
      unlock();
      bus_wr(OFS_CTRL, 32'h8001);
      bus_rd(OFS_CTRL, rd);
      check("trigger disarmed", rd, 32'h1);
      bus_wr(OFS_CTRL, 32'h4001);
      bus_wr(OFS_CTRL, 32'hC002);
      bus_rd(OFS_CTRL, rd);
      check("locked and select held", rd, 32'h4001);
      bus_wr(OFS_TADDR, 32'h100);
      for (int k = 0; k < 4; k++) bus_wr(9'(OFS_DATA0 + 9'(16 * k)), 32'hD000_0000 + k);
      bus_wr(OFS_SRC, 32'h2000_0040);
      for (int k = 1; k < 8; k++) begin
         run_op(4'(k), 1'b1, rd);
         check("op code", last_cmd.op, 4'(k));
         check("select field", rd[3:0], 4'(k));
         check("fail clear", rd[BIT_FAIL], 1'b0);
      end
      check("target", last_cmd.addr, 32'h100);
      check("data0", last_cmd.data[31:0], 32'hD000_0000);
      check("data3", last_cmd.data[127:96], 32'hD000_0003);
      check("source", last_cmd.src, 32'h2000_0040);
      check("irq raised", irq, 1'b1);
      bus_rd(OFS_IRQ_STAT, rd);
      check("done status", rd[IRQ_DONE], 1'b1);
      bus_wr(OFS_IRQ_STAT, 32'hF);
      check("irq cleared", irq, 1'b0);
      run_op(OP_CHIP_ERASE, 1'b0, rd);
      check("chip erase refused", rd[BIT_FAIL], 1'b1);
      fail_next <= 1'b1;
      delay <= 8'h28;
      fork
         run_op(OP_QUAD, 1'b1, rd);
         begin
            repeat (30) @(posedge clk);
            low_supply_detect <= 1'b1;
            high_temp_detect <= 1'b1;
         end
      join
      check("fail flag", rd[BIT_FAIL], 1'b1);
      check("low supply flag", rd[BIT_LOWSUP], 1'b1);
      check("hot flag", rd[BIT_HOT], 1'b1);
      bus_wr(OFS_IRQ_MASK, 32'h0);
      check("irq masked", irq, 1'b0);
      fail_next <= 1'b0;
      delay <= 8'h04;
      run_op(OP_NOP, 1'b0, rd);
      check("flags cleared", rd & 32'h3100, 32'h0);
      repeat (4) @(posedge clk);
      bus_rd(OFS_CTRL, rd);
      check("no capture idle", rd & 32'h1100, 32'h0);
      low_supply_detect <= 1'b0;
      high_temp_detect <= 1'b0;
      for (int k = 0; k < 3; k++) begin
         unlock();
         bus_wr(pr[k], lim[k]);
         bus_rd(pr[k], rd);
         check("limit", rd, lim[k]);
         bus_wr(OFS_TADDR, ta[k]);
         run_op(OP_PAGE_ERASE, 1'b0, rd);
         check("skip fail", rd[BIT_FAIL], 1'b1);
      end
      bus_wr(OFS_TADDR, 32'h200);
      run_op(OP_PAGE_ERASE, 1'b1, rd);
      check("open page ok", rd[BIT_FAIL], 1'b0);
      run_op(OP_ERASE_ALL, 1'b0, rd);
      check("erase all refused", rd[BIT_FAIL], 1'b1);
      run_op(4'hF, 1'b0, rd);
      check("reserved refused", rd[BIT_FAIL], 1'b1);
      unlock();
      bus_wr(OFS_LOWLIM, 32'h8000_0200);
      unlock();
      bus_wr(OFS_LOWLIM, 32'h0000_0000);
      bus_rd(OFS_LOWLIM, rd);
      check("frozen limit", rd, 32'h8000_0200);
      bus_wr(OFS_HIGHLIM, 32'h0000_0000);
      bus_rd(OFS_HIGHLIM, rd);
      check("locked limit", rd, 32'h0000_0800);
      bus_rd(OFS_LINE_STAT, rd);
      check("pin status", rd, 32'h0000_0001);
      final_report();
   end
endmodule
